// ===== src/sbfd_regs.svh
// Register offsets, field positions and reset values of the fast-disable
// and output-float bank. Assumes an 8-bit serial-bus register window.
`ifndef SBFD_REGS_SVH
`define SBFD_REGS_SVH

`define SBFD_OFS_FAST_DISABLE  8'h03
`define SBFD_OFS_OUTPUT_FLOAT  8'h04
`define SBFD_RST_FAST_DISABLE  8'h00
`define SBFD_RST_OUTPUT_FLOAT  8'h00
`define SBFD_FD_WMASK          8'h3f
`define SBFD_OF_WMASK          8'h1f
`define SBFD_BIT_KBD           5
`define SBFD_BIT_MOUSE         4
`define SBFD_BIT_SER1          3
`define SBFD_BIT_SER2          2
`define SBFD_BIT_PARP          1
`define SBFD_BIT_FDC           0
`define SBFD_FL_KBMS           4
`define SBFD_FL_SER1           3
`define SBFD_FL_SER2           2
`define SBFD_FL_PARP           1
`define SBFD_FL_FDC            0
`define SBFD_NMOD              6
`define SBFD_RST_RDATA         8'h00
`define SBFD_RST_MODS          6'h00

`endif

// ===== src/sbfd_pkg.sv
// Types shared by the fast-disable and output-float bank.
// Assumes the constants header is on the include path.
package sbfd_pkg;
    typedef logic [7:0] sbfd_byte_t;
    typedef logic [5:0] sbfd_mod_t;
endpackage : sbfd_pkg

// ===== src/sbfd_bank.sv
// Fast-disable and output-float register bank on the serial management bus.
// Assumes the bus engine gives one-cycle write and read strobes with offset.
`timescale 1ns/1ps
`include "sbfd_regs.svh"

// Behaviour
// - Fast-disable register at offset 03h, reset to 00h.
// - Master disables modules directly, bypassing each activation bit.
// - Bit 5 forces keyboard controller off, ignoring its activation bit.
// - Bit 4 forces mouse controller off, ignoring its activation bit.
// - Bit 3 forces first serial port off, ignoring its activation bit.
// - Bit 2 forces second serial port off, ignoring its activation bit.
// - Bit 1 forces parallel port off, ignoring its activation bit.
// - Bit 0 clear: module state follows its own activation bit.
// - Read/write output-float register at offset 04h, reset to 00h.
// - Float bit works without writing the special configuration bit.
// - Float takes effect only while the module is disabled.
// - Float bit 4 floats keyboard and mouse outputs when disabled.
// - Float bit 3 floats first serial port outputs when disabled.
module sbfd_bank (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 wr_stb,
    input  wire logic                 rd_stb,
    input  wire sbfd_pkg::sbfd_byte_t addr,
    input  wire sbfd_pkg::sbfd_byte_t wdata,
    output      sbfd_pkg::sbfd_byte_t rdata,
    output      logic                 rd_hit,
    input  wire sbfd_pkg::sbfd_mod_t  activation,
    input  wire sbfd_pkg::sbfd_mod_t  cfg_float,
    output      sbfd_pkg::sbfd_mod_t  module_enable,
    output      sbfd_pkg::sbfd_mod_t  module_float
);
    import sbfd_pkg::*;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    sbfd_byte_t module_fast_disable_r;
    sbfd_byte_t module_output_float_r;
    sbfd_byte_t rdata_r;
    logic       rd_hit_r;
    sbfd_mod_t  enable_nxt;
    sbfd_mod_t  float_nxt;
    sbfd_mod_t  force_off;
    sbfd_mod_t  float_req;

    // Offset match shared by write and read decode
    function automatic logic hit(input sbfd_byte_t a, input sbfd_byte_t o);
        hit = (a == o);
    endfunction : hit

    // Slot is live only when activated and not forced off
    function automatic logic slot_on(input logic act, input logic off);
        slot_on = act & ~off;
    endfunction : slot_on

    // Disabled slot floats when either float source asks for it
    function automatic logic slot_float(input logic on, input logic req,
                                        input logic cfg);
        slot_float = ~on & (req | cfg);
    endfunction : slot_float

    // Fast-disable register write; reserved bits forced to zero
    always_ff @(posedge clk) begin
        if (reset) begin
            module_fast_disable_r <= `SBFD_RST_FAST_DISABLE;
        end else if (wr_stb && hit(addr, `SBFD_OFS_FAST_DISABLE)) begin
            module_fast_disable_r <= wdata & `SBFD_FD_WMASK;
        end
    end

    // Output-float register write; bits 7..5 reserved
    always_ff @(posedge clk) begin
        if (reset) begin
            module_output_float_r <= `SBFD_RST_OUTPUT_FLOAT;
        end else if (wr_stb && hit(addr, `SBFD_OFS_OUTPUT_FLOAT)) begin
            module_output_float_r <= wdata & `SBFD_OF_WMASK;
        end
    end

    // Read data, registered; unmapped offsets read zero, no hit
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r  <= `SBFD_RST_RDATA;
            rd_hit_r <= 1'b0;
        end else if (rd_stb) begin
            rd_hit_r <= hit(addr, `SBFD_OFS_FAST_DISABLE) ||
                        hit(addr, `SBFD_OFS_OUTPUT_FLOAT);
            if (hit(addr, `SBFD_OFS_FAST_DISABLE)) begin
                rdata_r <= module_fast_disable_r;
            end else if (hit(addr, `SBFD_OFS_OUTPUT_FLOAT)) begin
                rdata_r <= module_output_float_r;
            end else begin
                rdata_r <= `SBFD_RST_RDATA;
            end
        end else begin
            rd_hit_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Module override logic
    // ------------------------------------------------------------
    // Force-off and float request vectors per module slot
    always_comb begin
        force_off = module_fast_disable_r[`SBFD_NMOD-1:0];
        float_req = '0;
        float_req[`SBFD_BIT_KBD]   = module_output_float_r[`SBFD_FL_KBMS];
        float_req[`SBFD_BIT_MOUSE] = module_output_float_r[`SBFD_FL_KBMS];
        float_req[`SBFD_BIT_SER1]  = module_output_float_r[`SBFD_FL_SER1];
        float_req[`SBFD_BIT_SER2]  = module_output_float_r[`SBFD_FL_SER2];
        float_req[`SBFD_BIT_PARP]  = module_output_float_r[`SBFD_FL_PARP];
        float_req[`SBFD_BIT_FDC]   = module_output_float_r[`SBFD_FL_FDC];
    end

    // Enable and float results
    always_comb begin
        // Force wins over activation; clear bit passes activation
        enable_nxt[`SBFD_BIT_KBD] = slot_on(activation[`SBFD_BIT_KBD],
            force_off[`SBFD_BIT_KBD]);
        enable_nxt[`SBFD_BIT_MOUSE] = slot_on(activation[`SBFD_BIT_MOUSE],
            force_off[`SBFD_BIT_MOUSE]);
        enable_nxt[`SBFD_BIT_SER1] = slot_on(activation[`SBFD_BIT_SER1],
            force_off[`SBFD_BIT_SER1]);
        enable_nxt[`SBFD_BIT_SER2] = slot_on(activation[`SBFD_BIT_SER2],
            force_off[`SBFD_BIT_SER2]);
        enable_nxt[`SBFD_BIT_PARP] = slot_on(activation[`SBFD_BIT_PARP],
            force_off[`SBFD_BIT_PARP]);
        enable_nxt[`SBFD_BIT_FDC] = slot_on(activation[`SBFD_BIT_FDC],
            force_off[`SBFD_BIT_FDC]);
        // Float only while disabled; either source suffices
        for (int i = 0; i < `SBFD_NMOD; i++) begin
            float_nxt[i] = slot_float(enable_nxt[i], float_req[i],
                cfg_float[i]);
        end
    end

    // Registered module controls
    always_ff @(posedge clk) begin
        if (reset) begin
            module_enable <= `SBFD_RST_MODS;
            module_float  <= `SBFD_RST_MODS;
        end else begin
            module_enable <= enable_nxt;
            module_float  <= float_nxt;
        end
    end

    assign rdata  = rdata_r;
    assign rd_hit = rd_hit_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Reset clears the fast-disable register
    AST_FD_RESET: assert property (@(posedge clk)
        reset |=> module_fast_disable_r == `SBFD_RST_FAST_DISABLE)
        else $error("fast-disable not cleared by reset");

    // Reset clears the output-float register
    AST_OF_RESET: assert property (@(posedge clk)
        reset |=> module_output_float_r == `SBFD_RST_OUTPUT_FLOAT)
        else $error("output-float not cleared by reset");

    // Reset drops both module control vectors
    AST_MOD_RESET: assert property (@(posedge clk)
        reset |=> module_enable == `SBFD_RST_MODS &&
                  module_float == `SBFD_RST_MODS)
        else $error("module controls not cleared by reset");

    // Write to the fast-disable offset lands next cycle
    AST_FD_WRITE: assert property (@(posedge clk)
        disable iff (reset)
        wr_stb && addr == `SBFD_OFS_FAST_DISABLE |=>
        module_fast_disable_r == ($past(wdata) & `SBFD_FD_WMASK))
        else $error("fast-disable write lost");

    // Write to the output-float offset lands next cycle
    AST_OF_WRITE: assert property (@(posedge clk)
        disable iff (reset)
        wr_stb && addr == `SBFD_OFS_OUTPUT_FLOAT |=>
        module_output_float_r == ($past(wdata) & `SBFD_OF_WMASK))
        else $error("output-float write lost");

    // Other offsets never touch either register
    AST_UNMAPPED_WRITE: assert property (@(posedge clk)
        disable iff (reset)
        wr_stb && !hit(addr, `SBFD_OFS_FAST_DISABLE) &&
        !hit(addr, `SBFD_OFS_OUTPUT_FLOAT) |=>
        $stable(module_fast_disable_r) && $stable(module_output_float_r))
        else $error("unmapped write changed a register");

    // Fast-disable read hits and shows zero reserved bits
    AST_FD_READBACK: assert property (@(posedge clk)
        disable iff (reset)
        rd_stb && addr == `SBFD_OFS_FAST_DISABLE |=>
        rd_hit && (rdata & ~`SBFD_FD_WMASK) == '0)
        else $error("fast-disable reserved bits nonzero");

    // Fast-disable read returns the stored value
    AST_FD_READ_DATA: assert property (@(posedge clk)
        disable iff (reset)
        rd_stb && addr == `SBFD_OFS_FAST_DISABLE |=>
        rdata == $past(module_fast_disable_r))
        else $error("fast-disable read data wrong");

    // Output-float read returns the stored value
    AST_OF_READBACK: assert property (@(posedge clk)
        disable iff (reset)
        rd_stb && addr == `SBFD_OFS_OUTPUT_FLOAT |=>
        rd_hit && rdata == $past(module_output_float_r))
        else $error("output-float read data wrong");

    // Unmapped read answers zero without a hit
    AST_UNMAPPED_READ: assert property (@(posedge clk)
        disable iff (reset)
        rd_stb && !hit(addr, `SBFD_OFS_FAST_DISABLE) &&
        !hit(addr, `SBFD_OFS_OUTPUT_FLOAT) |=>
        !rd_hit && rdata == `SBFD_RST_RDATA)
        else $error("unmapped read not zero");

    // Hit is a single pulse after a read strobe
    AST_HIT_PULSE: assert property (@(posedge clk)
        disable iff (reset)
        !rd_stb |=> !rd_hit)
        else $error("read hit without strobe");

    // Read data holds between read strobes
    AST_RDATA_HOLD: assert property (@(posedge clk)
        disable iff (reset)
        !rd_stb |=> $stable(rdata))
        else $error("read data changed without strobe");

    // Keyboard slot forced off
    AST_KBD_OFF: assert property (@(posedge clk)
        disable iff (reset)
        module_fast_disable_r[`SBFD_BIT_KBD] |=> !module_enable[`SBFD_BIT_KBD])
        else $error("keyboard not forced off");

    // Mouse slot forced off
    AST_MOUSE_OFF: assert property (@(posedge clk)
        disable iff (reset)
        module_fast_disable_r[`SBFD_BIT_MOUSE] |=> !module_enable[`SBFD_BIT_MOUSE])
        else $error("mouse not forced off");

    // First serial slot forced off
    AST_SER1_OFF: assert property (@(posedge clk)
        disable iff (reset)
        module_fast_disable_r[`SBFD_BIT_SER1] |=> !module_enable[`SBFD_BIT_SER1])
        else $error("serial one not forced off");

    // Second serial slot forced off
    AST_SER2_OFF: assert property (@(posedge clk)
        disable iff (reset)
        module_fast_disable_r[`SBFD_BIT_SER2] |=> !module_enable[`SBFD_BIT_SER2])
        else $error("serial two not forced off");

    // Parallel slot forced off
    AST_PARP_OFF: assert property (@(posedge clk)
        disable iff (reset)
        module_fast_disable_r[`SBFD_BIT_PARP] |=> !module_enable[`SBFD_BIT_PARP])
        else $error("parallel not forced off");

    // Floppy slot forced off
    AST_FDC_OFF: assert property (@(posedge clk)
        disable iff (reset)
        module_fast_disable_r[`SBFD_BIT_FDC] |=> !module_enable[`SBFD_BIT_FDC])
        else $error("floppy not forced off");

    // Clear register passes activation straight through
    AST_FOLLOW: assert property (@(posedge clk)
        disable iff (reset)
        module_fast_disable_r[`SBFD_NMOD-1:0] == `SBFD_RST_MODS |=>
        module_enable == $past(activation))
        else $error("enable does not follow activation");

    // No forced slot is ever enabled
    AST_FD_OVERRIDE: assert property (@(posedge clk)
        disable iff (reset)
        ##1 (module_enable &
             $past(module_fast_disable_r[`SBFD_NMOD-1:0])) == '0)
        else $error("forced slot still enabled");

    // Enabled slot never floats
    AST_FLOAT_ONLY_OFF: assert property (@(posedge clk)
        disable iff (reset)
        ##1 (module_float & module_enable) == '0)
        else $error("enabled module floated");

    // No float source means no float
    AST_NO_FLOAT_REQ: assert property (@(posedge clk)
        disable iff (reset)
        (float_req | cfg_float) == '0 |=>
        module_float == `SBFD_RST_MODS)
        else $error("float without a request");

    // Keyboard float while its slot is inactive
    AST_KBMS_FLOAT: assert property (@(posedge clk)
        disable iff (reset)
        module_output_float_r[`SBFD_FL_KBMS] && !activation[`SBFD_BIT_KBD] |=> module_float[`SBFD_BIT_KBD])
        else $error("keyboard float missing");

    // Mouse float while its slot is inactive
    AST_MOUSE_FLOAT: assert property (@(posedge clk)
        disable iff (reset)
        module_output_float_r[`SBFD_FL_KBMS] && !activation[`SBFD_BIT_MOUSE] |=> module_float[`SBFD_BIT_MOUSE])
        else $error("mouse float missing");

    // First serial float while forced off
    AST_SER1_FLOAT: assert property (@(posedge clk)
        disable iff (reset)
        module_output_float_r[`SBFD_FL_SER1] && module_fast_disable_r[`SBFD_BIT_SER1] |=> module_float[`SBFD_BIT_SER1])
        else $error("serial one float missing");

    // Float register works without the configuration bit
    AST_CFG_FREE: assert property (@(posedge clk)
        disable iff (reset)
        module_output_float_r[`SBFD_FL_PARP] && module_fast_disable_r[`SBFD_BIT_PARP] &&
        !cfg_float[`SBFD_BIT_PARP] |=> module_float[`SBFD_BIT_PARP])
        else $error("float needs config bit");

    // Main scenarios
    CVR_FORCE_KBD: cover property (@(posedge clk) disable iff (reset)
        activation[`SBFD_BIT_KBD] && module_fast_disable_r[`SBFD_BIT_KBD]
        ##1 !module_enable[`SBFD_BIT_KBD]);
    CVR_FLOAT_SER1: cover property (@(posedge clk) disable iff (reset)
        module_float[`SBFD_BIT_SER1]);
    CVR_READ_OF: cover property (@(posedge clk) disable iff (reset)
        rd_stb && addr == `SBFD_OFS_OUTPUT_FLOAT);
    CVR_CFG_FLOAT: cover property (@(posedge clk) disable iff (reset)
        !module_output_float_r[`SBFD_FL_FDC] && cfg_float[`SBFD_BIT_FDC]
        ##1 module_float[`SBFD_BIT_FDC]);
    CVR_UNMAPPED_READ: cover property (@(posedge clk) disable iff (reset)
        rd_stb && !hit(addr, `SBFD_OFS_FAST_DISABLE) &&
        !hit(addr, `SBFD_OFS_OUTPUT_FLOAT));
endmodule : sbfd_bank

// ===== sim/sbfd_ctrl_model.sv
// Serial-bus controller model: one-byte register writes and reads.
// Assumes the bank samples strobes, offset and data at the rising edge.
`timescale 1ns/1ps
module sbfd_ctrl_model (
    input  wire logic                 clk,
    output      logic                 wr_stb,
    output      logic                 rd_stb,
    output      sbfd_pkg::sbfd_byte_t addr,
    output      sbfd_pkg::sbfd_byte_t wdata,
    input  wire sbfd_pkg::sbfd_byte_t rdata,
    input  wire logic                 rd_hit
);
    import sbfd_pkg::*;
    // Idle bus
    initial begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr   = 8'h00;
        wdata  = 8'h00;
    end
    // Write: hold for one taken edge, then scramble the released lines
    task automatic write(input sbfd_byte_t a, input sbfd_byte_t d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
        addr   <= ~a;
        wdata  <= ~d;
    endtask : write
    // Read: answer is registered at the taken edge and sampled 1 ns after it
    task automatic read(input sbfd_byte_t a, output sbfd_byte_t d,
                        output logic h);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        addr   <= ~a;
        #1;
        d = rdata;
        h = rd_hit;
    endtask : read
endmodule : sbfd_ctrl_model

// ===== sim/sbfd_bank_tb.sv
// Self-checking bench for the fast-disable and output-float bank.
// Assumes the bank, package and register header are compiled first.
`timescale 1ns/1ps
`include "sbfd_regs.svh"
module sbfd_bank_tb;
    import sbfd_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wr_stb, rd_stb, rd_hit, h;
    sbfd_byte_t addr, wdata, rdata, d;
    sbfd_mod_t activation = 6'h00;
    sbfd_mod_t cfg_float = 6'h00;
    sbfd_mod_t module_enable, module_float;
    int err_count = 0;
    int comparisons = 0;
    always #20 clk = ~clk;
    sbfd_ctrl_model host (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .addr(addr), .wdata(wdata), .rdata(rdata), .rd_hit(rd_hit));
    sbfd_bank uut (.clk(clk), .reset(reset), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .addr(addr), .wdata(wdata), .rdata(rdata),
        .rd_hit(rd_hit), .activation(activation), .cfg_float(cfg_float),
        .module_enable(module_enable), .module_float(module_float));
    // Compare one byte
    task automatic chk(input sbfd_byte_t g, input sbfd_byte_t e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // Let register and module outputs update
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic t_reset;
        host.read(`SBFD_OFS_FAST_DISABLE, d, h);
        chk(d, 8'h00);
        chk({7'h00, h}, 8'h01);
        host.read(`SBFD_OFS_OUTPUT_FLOAT, d, h);
        chk(d, 8'h00);
    endtask : t_reset
    task automatic t_disable;
        @(posedge clk) activation <= 6'h3f;
        for (int i = 0; i < 6; i++) begin
            host.write(`SBFD_OFS_FAST_DISABLE, 8'h01 << i);
            settle();
            chk({2'h0, module_enable}, 8'h3f & ~(8'h01 << i));
        end
        host.write(`SBFD_OFS_FAST_DISABLE, 8'hff);
        host.read(`SBFD_OFS_FAST_DISABLE, d, h);
        chk(d, 8'h3f);
        host.write(`SBFD_OFS_FAST_DISABLE, 8'h00);
        @(posedge clk) activation <= 6'h15;
        settle();
        chk({2'h0, module_enable}, 8'h15);
    endtask : t_disable
    task automatic t_float;
        @(posedge clk) activation <= 6'h3f;
        host.write(`SBFD_OFS_OUTPUT_FLOAT, 8'hff);
        settle();
        chk({2'h0, module_float}, 8'h00);
        host.read(`SBFD_OFS_OUTPUT_FLOAT, d, h);
        chk(d, 8'h1f);
        host.write(`SBFD_OFS_FAST_DISABLE, 8'h3f);
        settle();
        chk({2'h0, module_float}, 8'h3f);
        host.write(`SBFD_OFS_OUTPUT_FLOAT, 8'h08);
        settle();
        chk({2'h0, module_float}, 8'h08);
    endtask : t_float
    task automatic t_unmapped;
        host.write(8'h05, 8'hff);
        host.read(8'h05, d, h);
        chk(d, 8'h00);
        chk({7'h00, h}, 8'h00);
        host.read(`SBFD_OFS_OUTPUT_FLOAT, d, h);
        chk(d, 8'h08);
    endtask : t_unmapped
    // Configuration float path, and float of inactive slots
    task automatic t_cfg_float;
        host.write(`SBFD_OFS_OUTPUT_FLOAT, 8'h00);
        host.write(`SBFD_OFS_FAST_DISABLE, 8'h03);
        @(posedge clk) cfg_float <= 6'h3f;
        settle();
        chk({2'h0, module_enable}, 8'h3c);
        chk({2'h0, module_float}, 8'h03);
        @(posedge clk) cfg_float <= 6'h00;
        host.write(`SBFD_OFS_OUTPUT_FLOAT, 8'h10);
        host.write(`SBFD_OFS_FAST_DISABLE, 8'h00);
        @(posedge clk) activation <= 6'h0f;
        settle();
        chk({2'h0, module_float}, 8'h30);
    endtask : t_cfg_float
    // Reset in mid-run clears both registers and module controls
    task automatic t_mid_reset;
        host.write(`SBFD_OFS_FAST_DISABLE, 8'h21);
        @(posedge clk) reset <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({2'h0, module_enable}, 8'h00);
        chk({2'h0, module_float}, 8'h00);
        @(posedge clk) reset <= 1'b0;
        host.read(`SBFD_OFS_FAST_DISABLE, d, h);
        chk(d, 8'h00);
        host.read(`SBFD_OFS_OUTPUT_FLOAT, d, h);
        chk(d, 8'h00);
        settle();
        chk({2'h0, module_enable}, 8'h0f);
    endtask : t_mid_reset
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        end_sim();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_disable();
        t_float();
        t_unmapped();
        t_cfg_float();
        t_mid_reset();
        end_sim();
    end
endmodule : sbfd_bank_tb
